// ### core/bbp_regs.vh
`ifndef BBP_REGS_VH
`define BBP_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define BBP_OFS_CTRL 8'h00
`define BBP_OFS_BAUD 8'h04
`define BBP_OFS_SYSCTL 8'h08
`define BBP_OFS_STATUS 8'h0C
`define BBP_OFS_LOAD 8'h10
`define BBP_OFS_JUMP 8'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BBP_CTRL_EN 0
`define BBP_SYSCTL_SWAP 0
`define BBP_BAUD_RST 16'h01B2

// ----------------------------------------------------------------
// block types, modes and answer codes
// ----------------------------------------------------------------
`define BBP_TYPE_HDR 8'h00
`define BBP_TYPE_DATA 8'h01
`define BBP_TYPE_EOT 8'h02
`define BBP_MODE_LOAD 8'h00
`define BBP_MODE_RUNRAM 8'h01
`define BBP_MODE_FCHK 8'h02
`define BBP_MODE_RUNFL 8'h03
`define BBP_ACK 8'h55
`define BBP_ERR_CSUM 8'hFE
`define BBP_ERR_BLK 8'hFF

// ----------------------------------------------------------------
// frame and block sizes
// ----------------------------------------------------------------
`define BBP_HDR_LEN 8'h08
// one spare shift keeps the second stop bit a full bit time
`define BBP_TX_BITS 4'hC
`define BBP_BUF_DEPTH 128

`endif

// ### core/bbp_loader.v
`timescale 1ns/1ps
`include "bbp_regs.vh"

// Operation
// - first byte is type: 00H header, 01H data, 02H end of transmission
// - device recomputes xor; mismatch answered with FEH
// - type not acceptable at this point is answered with FFH
// - after an error byte the block is dropped and state holds
// - block passing type and checksum checks is answered with 55H
// - device only ever sends single answer bytes, never blocks
// - header block is always eight bytes including checksum
// - phase starts waiting for a header; no mode before valid header
// - header is type, mode, five parameter bytes, checksum
// - mode byte picks load, run from ram, flash check, run flash
// - in mode 0 a header or type above 02H gets FFH
// - mode 0 params: origin high, low, payload length; rest ignored
// - data payload goes to extended ram at consecutive addresses
// - end block count field limits how many bytes are stored
// - mode 1 sets swap bit and jumps to start address, no more exchange
// - serial link is 8 data bits, no parity, two stop bits
// - mode 2 answers 55H on flash checksum match, FEH otherwise
module bbp_loader (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd,
  output reg txd,
  output reg ram_we,
  output reg [15:0] ram_addr,
  output reg [7:0] ram_wdata,
  output reg code_from_ram,
  output reg jump_valid,
  output reg jump_to_flash,
  output reg [15:0] jump_addr,
  output reg flash_chk_req,
  output reg [15:0] flash_chk_addr,
  output reg [15:0] flash_chk_len,
  input wire flash_chk_done,
  input wire flash_chk_ok
);

  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_HDR = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_COPY = 3'h3;
  localparam [2:0] ST_FCHK = 3'h4;
  localparam [2:0] ST_FRES = 3'h5;
  localparam [2:0] ST_RUN = 3'h6;

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg enable;
  reg [15:0] baud_div;
  reg [2:0] state;
  reg [1:0] mode;
  reg [7:0] last_resp;
  reg [7:0] blen;
  reg [7:0] blk_type;
  reg [7:0] blk_idx;
  reg [7:0] csum_acc;
  reg [7:0] eot_cnt;
  reg [7:0] copy_n;
  reg [6:0] copy_idx;
  reg [7:0] buf_mem [0:`BBP_BUF_DEPTH-1];
  reg rxd_s1;
  reg rxd_s2;
  reg [15:0] rx_cnt;
  reg [3:0] rx_bit;
  reg rx_busy;
  reg [7:0] rx_shift;
  reg rx_valid;
  reg [7:0] rx_byte;
  reg [15:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [10:0] tx_shift;
  reg tx_go;
  reg [7:0] tx_byte;
  wire tx_busy;
  wire apb_acc;
  wire [7:0] blk_len;
  wire [7:0] last_xor;
  wire [7:0] eot_keep;

  function [7:0] min8;
    input [7:0] a;
    input [7:0] b;
    begin
      min8 = (a < b) ? a : b;
    end
  endfunction

  assign tx_busy = (tx_bit != 4'h0);
  assign apb_acc = psel & penable & ~pready;
  // block length: header length in ST_HDR, else from the latched payload length
  assign blk_len = (state == ST_HDR) ? `BBP_HDR_LEN :
    (blk_type == `BBP_TYPE_EOT) ? blen + 8'h03 : blen + 8'h02;
  assign last_xor = csum_acc ^ rx_byte;
  assign eot_keep = min8(eot_cnt, blen);

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      enable <= 1'b0;
      baud_div <= `BBP_BAUD_RST;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_acc)
      begin
        case (paddr)
          `BBP_OFS_CTRL:
          begin
            prdata <= {31'h00000000, enable};
            if (pwrite)
              enable <= pwdata[`BBP_CTRL_EN];
          end
          `BBP_OFS_BAUD:
          begin
            prdata <= {16'h0000, baud_div};
            if (pwrite)
              baud_div <= pwdata[15:0];
          end
          `BBP_OFS_SYSCTL:
            prdata <= {31'h00000000, code_from_ram};
          `BBP_OFS_STATUS:
            prdata <= {8'h00, last_resp, 6'h00, mode, 5'h00, state};
          `BBP_OFS_LOAD:
            prdata <= {16'h0000, ram_addr};
          `BBP_OFS_JUMP:
            prdata <= {15'h0000, jump_to_flash, jump_addr};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // serial receiver, 8 data bits, stop bit checked
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_busy <= 1'b0;
      rx_shift <= 8'h00;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end
    else
    begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      rx_valid <= 1'b0;
      if (!rx_busy)
      begin
        rx_cnt <= {1'b0, baud_div[15:1]};
        rx_bit <= 4'h0;
        if (!rxd_s2 && enable)
          rx_busy <= 1'b1;
      end
      else if (rx_cnt != 16'h0000)
        rx_cnt <= rx_cnt - 16'h0001;
      else
      begin
        rx_cnt <= baud_div;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0)
          rx_busy <= ~rxd_s2;
        else if (rx_bit == 4'h9)
        begin
          // a missing stop bit drops the byte
          rx_busy <= 1'b0;
          rx_valid <= rxd_s2;
          rx_byte <= rx_shift;
        end
        else
          rx_shift <= {rxd_s2, rx_shift[7:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // serial transmitter, start, 8 data, two stop bits
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      txd <= 1'b1;
      tx_cnt <= 16'h0000;
      tx_bit <= 4'h0;
      tx_shift <= 11'h7FF;
    end
    else if (!tx_busy)
    begin
      txd <= 1'b1;
      if (tx_go)
      begin
        tx_shift <= {2'b11, tx_byte, 1'b0};
        tx_bit <= `BBP_TX_BITS;
        tx_cnt <= 16'h0000;
      end
    end
    else if (tx_cnt != 16'h0000)
      tx_cnt <= tx_cnt - 16'h0001;
    else
    begin
      txd <= tx_shift[0];
      tx_shift <= {1'b1, tx_shift[10:1]};
      tx_cnt <= baud_div;
      tx_bit <= tx_bit - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // block buffer
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rx_valid && blk_idx != 8'h00)
    begin
      if (blk_type == `BBP_TYPE_EOT && state == ST_LOAD)
        buf_mem[blk_idx[6:0] - 7'h02] <= rx_byte;
      else
        buf_mem[blk_idx[6:0] - 7'h01] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // block protocol
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= ST_OFF;
      mode <= 2'h0;
      last_resp <= 8'h00;
      blen <= 8'h00;
      blk_type <= 8'h00;
      blk_idx <= 8'h00;
      csum_acc <= 8'h00;
      eot_cnt <= 8'h00;
      copy_n <= 8'h00;
      copy_idx <= 7'h00;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
      ram_we <= 1'b0;
      ram_addr <= 16'h0000;
      ram_wdata <= 8'h00;
      code_from_ram <= 1'b0;
      jump_valid <= 1'b0;
      jump_to_flash <= 1'b0;
      jump_addr <= 16'h0000;
      flash_chk_req <= 1'b0;
      flash_chk_addr <= 16'h0000;
      flash_chk_len <= 16'h0000;
    end
    else
    begin
      tx_go <= 1'b0;
      ram_we <= 1'b0;
      jump_valid <= 1'b0;
      flash_chk_req <= 1'b0;
      // hardware set wins over a software clear
      if (apb_acc && pwrite && paddr == `BBP_OFS_SYSCTL)
        code_from_ram <= pwdata[`BBP_SYSCTL_SWAP];
      if (!enable)
      begin
        state <= ST_OFF;
        blk_idx <= 8'h00;
        csum_acc <= 8'h00;
      end
      else
      begin
        case (state)
          ST_OFF:
            state <= ST_HDR;
          ST_HDR, ST_LOAD:
          begin
            if (rx_valid)
            begin
              csum_acc <= csum_acc ^ rx_byte;
              blk_idx <= blk_idx + 8'h01;
              if (blk_idx == 8'h00)
                blk_type <= rx_byte;
              if (blk_idx == 8'h01)
                eot_cnt <= rx_byte;
              if (blk_idx != 8'h00 && blk_idx + 8'h01 == blk_len)
              begin
                // block complete: restart index and checksum for the next block
                blk_idx <= 8'h00;
                csum_acc <= 8'h00;
                tx_go <= 1'b1;
                if (last_xor != 8'h00)
                begin
                  tx_byte <= `BBP_ERR_CSUM;
                  last_resp <= `BBP_ERR_CSUM;
                end
                else if (state == ST_HDR && blk_type != `BBP_TYPE_HDR)
                begin
                  tx_byte <= `BBP_ERR_BLK;
                  last_resp <= `BBP_ERR_BLK;
                end
                else if (state == ST_LOAD &&
                  blk_type != `BBP_TYPE_DATA &&
                  blk_type != `BBP_TYPE_EOT)
                begin
                  tx_byte <= `BBP_ERR_BLK;
                  last_resp <= `BBP_ERR_BLK;
                end
                else if (state == ST_HDR)
                begin
                  tx_byte <= `BBP_ACK;
                  last_resp <= `BBP_ACK;
                  mode <= buf_mem[0][1:0];
                  case (buf_mem[0])
                    `BBP_MODE_LOAD:
                    begin
                      ram_addr <= {buf_mem[1], buf_mem[2]};
                      blen <= buf_mem[3];
                      state <= ST_LOAD;
                    end
                    `BBP_MODE_RUNRAM:
                    begin
                      code_from_ram <= 1'b1;
                      jump_addr <= {buf_mem[1], buf_mem[2]};
                      jump_to_flash <= 1'b0;
                      jump_valid <= 1'b1;
                      state <= ST_RUN;
                    end
                    `BBP_MODE_FCHK:
                    begin
                      flash_chk_addr <= {buf_mem[1], buf_mem[2]};
                      flash_chk_len <= {buf_mem[3], buf_mem[4]};
                      flash_chk_req <= 1'b1;
                      state <= ST_FCHK;
                    end
                    `BBP_MODE_RUNFL:
                    begin
                      jump_addr <= {buf_mem[1], buf_mem[2]};
                      jump_to_flash <= 1'b1;
                      jump_valid <= 1'b1;
                      state <= ST_RUN;
                    end
                    default:
                      state <= ST_HDR;
                  endcase
                end
                else
                begin
                  // answer after the payload is written
                  tx_go <= 1'b0;
                  copy_idx <= 7'h00;
                  if (blk_type == `BBP_TYPE_EOT)
                    copy_n <= eot_keep;
                  else
                    copy_n <= blen;
                  state <= ST_COPY;
                end
              end
            end
          end
          ST_COPY:
          begin
            if ({1'b0, copy_idx} != copy_n)
            begin
              ram_we <= 1'b1;
              ram_wdata <= buf_mem[copy_idx];
              copy_idx <= copy_idx + 7'h01;
              if (ram_we)
                ram_addr <= ram_addr + 16'h0001;
            end
            else
            begin
              if (ram_we)
                ram_addr <= ram_addr + 16'h0001;
              tx_go <= 1'b1;
              tx_byte <= `BBP_ACK;
              last_resp <= `BBP_ACK;
              if (blk_type == `BBP_TYPE_EOT)
                state <= ST_HDR;
              else
                state <= ST_LOAD;
            end
          end
          ST_FCHK:
          begin
            if (flash_chk_done)
            begin
              tx_byte <= flash_chk_ok ? `BBP_ACK : `BBP_ERR_CSUM;
              last_resp <= flash_chk_ok ? `BBP_ACK : `BBP_ERR_CSUM;
              state <= ST_FRES;
            end
          end
          ST_FRES:
          begin
            // wait for the header answer to leave the line
            if (!tx_busy && !tx_go)
            begin
              tx_go <= 1'b1;
              state <= ST_HDR;
            end
          end
          ST_RUN:
            state <= ST_RUN;
          default:
            state <= ST_OFF;
        endcase
      end
    end
  end

endmodule

// ### dv/bbp_loader_chk.sv
`timescale 1ns/1ps
`include "bbp_regs.vh"
// ----------------------------------------
// port checker for the boot block loader
// ----------------------------------------
module bbp_loader_chk (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire txd,
  input wire ram_we,
  input wire [15:0] ram_addr,
  input wire code_from_ram,
  input wire jump_valid,
  input wire jump_to_flash,
  input wire flash_chk_req
);
  reg [15:0] baud_q;
  reg [15:0] low_cnt;
  wire wr_baud;

  assign wr_baud = psel && penable && pready && pwrite
    && paddr == `BBP_OFS_BAUD;

  // tracks the bit period and the length of each low run on txd
  always @(posedge clk)
  begin
    baud_q <= !rst_n ? `BBP_BAUD_RST : wr_baud ? pwdata[15:0] : baud_q;
    low_cnt <= (!rst_n || txd) ? 16'h0000 : low_cnt + 16'h0001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ram_step_a:
    assert property (ram_we |=> ram_addr == $past(ram_addr) + 16'h0001)
    else $error("load address did not advance after a write");
  swap_on_jump_a:
    assert property (jump_valid && !jump_to_flash |=> code_from_ram)
    else $error("ram jump without swap bit");
  run_quiet_a:
    assert property (jump_valid && !jump_to_flash
      |=> (!ram_we && !flash_chk_req) [*8])
    else $error("activity after ram jump");
  jump_once_a:
    assert property (jump_valid |=> !jump_valid [*8])
    else $error("jump pulse repeated");
  flash_noswap_a:
    assert property (jump_valid && jump_to_flash |-> !code_from_ram)
    else $error("flash jump with swap bit set");
  copy_before_ack_a:
    assert property (ram_we |-> txd)
    else $error("ram write while answer is on the line");
  mode_excl_a:
    assert property ($onehot0({ram_we, jump_valid, flash_chk_req}))
    else $error("two mode actions at once");
  bit_time_a:
    assert property ($rose(txd)
      |-> (low_cnt % ({1'b0, baud_q} + 17'h00001)) == 17'h00000)
    else $error("low run on txd is not whole bit times");
endmodule

bind bbp_loader bbp_loader_chk i_bbp_loader_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .txd(txd), .ram_we(ram_we), .ram_addr(ram_addr),
  .code_from_ram(code_from_ram), .jump_valid(jump_valid),
  .jump_to_flash(jump_to_flash), .flash_chk_req(flash_chk_req)
);

// ### dv/bbp_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// serial host sending transfer blocks
// ----------------------------------------
module bbp_host #(
  parameter BIT_CLKS = 16
) (
  input wire clk,
  input wire txd,
  output logic rxd
);
  logic [7:0] rxq[$];
  logic [7:0] rb;
  integer k;
  integer n_stop_err = 0;

  initial rxd = 1'b1;

  // answer bytes, sampled in mid-bit
  initial
  forever
  begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (k = 0; k < 10; k++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      if (k < 8)
        rb[k] = txd;
      else if (txd !== 1'b1)
        n_stop_err++;
    end
    rxq.push_back(rb);
  end

  task send_byte(input logic [7:0] b);
    logic [10:0] f;
    integer i;
    f = {2'b11, b, 1'b0};
    for (i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask

  // type byte first, then data, then xor of both
  task send_blk(input logic [7:0] q[$], input logic bad);
    logic [7:0] cs;
    integer i;
    cs = bad ? 8'h5A : 8'h00;
    for (i = 0; i < q.size(); i++)
    begin
      cs = cs ^ q[i];
      send_byte(q[i]);
    end
    send_byte(cs);
  endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "bbp_regs.vh"
// ----------------------------------------
// boot block loader bench
// ----------------------------------------
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic flash_chk_done = 1'b0;
  logic flash_chk_ok = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, rxd, txd, ram_we, code_from_ram, jump_valid;
  wire jump_to_flash, flash_chk_req;
  wire [15:0] ram_addr, jump_addr, flash_chk_addr, flash_chk_len;
  wire [7:0] ram_wdata;
  logic [23:0] ramq[$];
  logic [7:0] blk[$];
  integer n_fail = 0;
  integer num_checks = 0;
  integer n_jump = 0;
  integer n_req = 0;
  integer i;

  always #10 clk = ~clk;

  bbp_loader i_bbp_loader (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .code_from_ram(code_from_ram), .jump_valid(jump_valid),
    .jump_to_flash(jump_to_flash), .jump_addr(jump_addr),
    .flash_chk_req(flash_chk_req), .flash_chk_addr(flash_chk_addr),
    .flash_chk_len(flash_chk_len), .flash_chk_done(flash_chk_done),
    .flash_chk_ok(flash_chk_ok)
  );
  bbp_host #(.BIT_CLKS(16)) i_bbp_host (.clk(clk), .txd(txd), .rxd(rxd));

  always @(posedge clk)
  begin
    if (ram_we === 1'b1)
      ramq.push_back({ram_addr, ram_wdata});
    if (jump_valid === 1'b1)
      n_jump++;
    if (flash_chk_req === 1'b1)
      n_req++;
  end

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    integer n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50)
    begin
      n_fail++;
      final_report;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask

  task wait_ans(input logic [7:0] exp);
    integer n;
    n = 0;
    while (i_bbp_host.rxq.size() == 0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      n_fail++;
      final_report;
    end
    else
      chk({24'h0, i_bbp_host.rxq.pop_front()}, {24'h0, exp});
  endtask

  task xfer(input logic bad, input logic [7:0] exp);
    i_bbp_host.send_blk(blk, bad);
    wait_ans(exp);
  endtask

  task wait_for(input logic jmp, input integer t);
    integer n;
    integer c;
    n = 0;
    c = jmp ? n_jump : n_req;
    while (c < t && n < 500)
    begin
      @(posedge clk);
      n++;
      c = jmp ? n_jump : n_req;
    end
    chk(c, t);
    if (n >= 500)
      final_report;
  endtask

  task do_reset;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // sixteen clocks per bit keeps frames short
  task cfg;
    wr(`BBP_OFS_BAUD, 32'h0000000F);
    wr(`BBP_OFS_CTRL, 32'h00000001);
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    do_reset;
    rd(`BBP_OFS_BAUD, {16'h0, `BBP_BAUD_RST}, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    cfg;
    blk = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
    xfer(1'b0, `BBP_ERR_BLK);
    blk = '{8'h00, 8'h00, 8'hF4, 8'h00, 8'h04, 8'h00, 8'h00};
    xfer(1'b1, `BBP_ERR_CSUM);
    rd(`BBP_OFS_STATUS, 32'h00FE0001, 1'b0);
    xfer(1'b0, `BBP_ACK);
    rd(`BBP_OFS_LOAD, 32'h0000F400, 1'b0);
    rd(`BBP_OFS_CTRL, 32'h00000001, 1'b0);
    $display("test header done");
    blk = '{8'h01, 8'h11, 8'h22, 8'h33, 8'h44};
    xfer(1'b1, `BBP_ERR_CSUM);
    blk[0] = 8'h00;
    xfer(1'b0, `BBP_ERR_BLK);
    blk[0] = 8'h03;
    xfer(1'b0, `BBP_ERR_BLK);
    blk[0] = 8'h01;
    xfer(1'b0, `BBP_ACK);
    blk = '{8'h02, 8'h02, 8'h55, 8'h66, 8'h77, 8'h88};
    xfer(1'b0, `BBP_ACK);
    rd(`BBP_OFS_LOAD, 32'h0000F406, 1'b0);
    chk(ramq.size(), 32'd6);
    for (i = 0; i < 6; i++)
      chk({8'h0, ramq[i]},
        {8'h0, 16'hF400 + i[15:0], 8'h11 * (i[7:0] + 8'h01)});
    $display("test load done");
    blk = '{8'h00, 8'h02, 8'h12, 8'h34, 8'h00, 8'h40, 8'h00};
    for (i = 0; i < 2; i++)
    begin
      // result comes while the header answer is still on the line
      i_bbp_host.send_blk(blk, 1'b0);
      wait_for(1'b0, i + 1);
      chk({flash_chk_addr, flash_chk_len}, 32'h12340040);
      flash_chk_ok <= i[0];
      flash_chk_done <= 1'b1;
      @(posedge clk);
      flash_chk_done <= 1'b0;
      wait_ans(`BBP_ACK);
      wait_ans(i[0] ? `BBP_ACK : `BBP_ERR_CSUM);
    end
    blk = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    xfer(1'b0, `BBP_ACK);
    rd(`BBP_OFS_STATUS, 32'h00550001, 1'b0);
    chk(n_req, 32'd2);
    $display("test flash check done");
    blk = '{8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    xfer(1'b0, `BBP_ACK);
    wait_for(1'b1, 1);
    rd(`BBP_OFS_JUMP, 32'h00010300, 1'b0);
    $display("test flash jump done");
    do_reset;
    cfg;
    blk = '{8'h00, 8'h01, 8'hF4, 8'h20, 8'h00, 8'h00, 8'h00};
    xfer(1'b0, `BBP_ACK);
    wait_for(1'b1, 2);
    rd(`BBP_OFS_JUMP, 32'h0000F420, 1'b0);
    rd(`BBP_OFS_SYSCTL, 32'h00000001, 1'b0);
    chk({31'h0, code_from_ram}, 32'h00000001);
    rd(`BBP_OFS_STATUS, 32'h00550106, 1'b0);
    wr(`BBP_OFS_SYSCTL, 32'h00000000);
    rd(`BBP_OFS_SYSCTL, 32'h00000000, 1'b0);
    chk(i_bbp_host.rxq.size(), 32'd0);
    chk(i_bbp_host.n_stop_err, 32'd0);
    $display("test ram jump done");
    final_report;
  end
endmodule
